/* File: rtl/arct_map.svh */
// register addresses, control bit positions, reset values and divider counts of the timer
`ifndef ARCT_MAP_SVH
`define ARCT_MAP_SVH

// ************************************************************
// special function register addresses
// ************************************************************
`define ARCT_ADDR_CTRL      8'hC8
`define ARCT_ADDR_RELOAD_LO 8'hCA
`define ARCT_ADDR_RELOAD_HI 8'hCB
`define ARCT_ADDR_COUNT_LO  8'hCC
`define ARCT_ADDR_COUNT_HI  8'hCD

// ************************************************************
// control register bit positions
// ************************************************************
`define ARCT_BIT_HI_FLAG    7
`define ARCT_BIT_LO_FLAG    6
`define ARCT_BIT_LO_IRQ_EN  5
`define ARCT_BIT_CAPTURE_EN 4
`define ARCT_BIT_SPLIT      3
`define ARCT_BIT_RUN        2
`define ARCT_BIT_CAP_SRC    1
`define ARCT_BIT_EXT_SEL    0

// ************************************************************
// reset values and count constants
// ************************************************************
`define ARCT_RST_BYTE       8'h00
`define ARCT_BYTE_ONES      8'hFF
`define ARCT_BYTE_ONE       8'h01
`define ARCT_WORD_ONES      16'hFFFF
`define ARCT_WORD_ONE       16'h0001
`define ARCT_DIV12_LAST     4'hB
`define ARCT_DIV12_ONE      4'h1
`define ARCT_DIV12_ZERO     4'h0
`define ARCT_EXT_LAST       3'h7
`define ARCT_EXT_ONE        3'h1
`define ARCT_EXT_ZERO       3'h0

`endif

/* File: rtl/arct_pkg.sv */
// types shared by the timer modules
package arct_pkg;

  // ************************************************************
  // operating modes, coded as {capture enable, split}
  // ************************************************************
  typedef enum logic [1:0] {
    ARCT_MODE_RELOAD16 = 2'b00,  // one 16-bit auto-reload counter
    ARCT_MODE_SPLIT8   = 2'b01,  // two 8-bit auto-reload counters
    ARCT_MODE_CAP16    = 2'b10,  // 16-bit free run with capture
    ARCT_MODE_CAP8     = 2'b11   // two 8-bit free run with capture
  } arct_mode_e;

endpackage : arct_pkg

/* File: rtl/arct_tick_gen.sv */
// prescaler: system clock over twelve and synchronized external clock over eight
`timescale 1ns/1ps
`include "arct_map.svh"
module arct_tick_gen (
  input  wire logic  i_sys_clk,
  input  wire logic  i_srst,
  input  wire logic  i_ext_osc,
  arct_tick_if.gen   tick
);

  // ************************************************************
  // state
  // ************************************************************
  logic [3:0] div12_cnt;       // system clock divider phase
  logic [3:0] next_div12_cnt;
  logic [2:0] ext_cnt;         // external rising edge count
  logic [2:0] next_ext_cnt;
  logic       ext_s1;          // first synchroniser stage, read only by ext_s2
  logic       ext_s2;          // second synchroniser stage
  logic       ext_s3;          // delayed copy for edge detection
  logic       sys12_q;         // registered divide-by-twelve tick
  logic       next_sys12_q;
  logic       ext8_q;          // registered divide-by-eight tick
  logic       next_ext8_q;
  logic       ext_rise;        // synchronized rising edge of the oscillator

  // ************************************************************
  // next state
  // ************************************************************
  // the oscillator is sampled twice before the edge detector sees it
  always_comb begin
    ext_rise       = ext_s2 & ~ext_s3;
    next_div12_cnt = (div12_cnt == `ARCT_DIV12_LAST) ? `ARCT_DIV12_ZERO
                                                     : div12_cnt + `ARCT_DIV12_ONE;
    next_sys12_q   = (div12_cnt == `ARCT_DIV12_LAST);
    next_ext_cnt   = ext_rise ? ext_cnt + `ARCT_EXT_ONE : ext_cnt;
    next_ext8_q    = ext_rise & (ext_cnt == `ARCT_EXT_LAST);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      div12_cnt <= `ARCT_DIV12_ZERO;
      ext_cnt   <= `ARCT_EXT_ZERO;
      ext_s1    <= 1'b0;
      ext_s2    <= 1'b0;
      ext_s3    <= 1'b0;
      sys12_q   <= 1'b0;
      ext8_q    <= 1'b0;
    end else begin
      div12_cnt <= next_div12_cnt;
      ext_cnt   <= next_ext_cnt;
      ext_s1    <= i_ext_osc;
      ext_s2    <= ext_s1;
      ext_s3    <= ext_s2;
      sys12_q   <= next_sys12_q;
      ext8_q    <= next_ext8_q;
    end
  end

  assign tick.sys12_tick = sys12_q;
  assign tick.ext8_tick  = ext8_q;

  // ************************************************************
  // checks
  // ************************************************************
  chk_div12_period: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    sys12_q |-> ##12 sys12_q) else $error("divide by twelve tick period wrong");
  chk_ext_tick_sync: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    ext8_q |-> $past(ext_s2) && !$past(ext_s3)) else $error("external tick not from synced edge");

endmodule : arct_tick_gen

/* File: rtl/arct_tick_if.sv */
// count tick pulses passed from the tick generator to the timer core
`timescale 1ns/1ps
interface arct_tick_if;
  logic sys12_tick;  // one pulse every twelve system clocks
  logic ext8_tick;   // one pulse every eight rising edges of the external oscillator

  modport gen (output sys12_tick, output ext8_tick);
  modport use_side (input sys12_tick, input ext8_tick);
endinterface : arct_tick_if

/* File: rtl/arct_timer.sv */
// 16-bit auto-reload and capture timer with its special function registers
`timescale 1ns/1ps
`include "arct_map.svh"
module arct_timer (
  input  wire logic       i_sys_clk,                  // system clock
  input  wire logic       i_srst,                     // synchronous reset, active high
  input  wire logic [7:0] i_sfr_addr,                 // register address
  input  wire logic       i_sfr_wr,                   // write strobe
  input  wire logic [7:0] i_sfr_wdata,                // write data
  output logic      [7:0] o_sfr_rdata,                // read data, one cycle after address
  output logic            o_sfr_hit,                  // address belongs to this timer
  input  wire logic       i_low_byte_clock_select,    // low byte runs on system clock
  input  wire logic       i_high_byte_clock_select,   // high byte runs on system clock in split modes
  input  wire logic       i_timer_irq_enable,         // global enable of timer interrupt
  input  wire logic       i_usb_sof,                  // start-of-frame pulse, same clock
  input  wire logic       i_ext_osc,                  // external oscillator, asynchronous
  input  wire logic       i_low_freq_oscillator,      // low frequency oscillator, asynchronous
  output logic            o_timer_irq                 // interrupt request level
);

  // ************************************************************
  // state and wiring
  // ************************************************************
  logic [7:0] ctrl;            // timer control register
  logic [7:0] next_ctrl;
  logic [7:0] reload_lo;       // low reload or captured byte
  logic [7:0] next_reload_lo;
  logic [7:0] reload_hi;       // high reload or captured byte
  logic [7:0] next_reload_hi;
  logic [7:0] count_lo;        // low count byte
  logic [7:0] next_count_lo;
  logic [7:0] count_hi;        // high count byte
  logic [7:0] next_count_hi;
  logic [7:0] rdata;           // registered read data
  logic [7:0] next_rdata;
  logic       slow_s1;         // first synchroniser stage, read only by slow_s2
  logic       slow_s2;         // second synchroniser stage
  logic       slow_s3;         // delayed copy for edge detection
  logic       slow_fall;       // synchronized falling edge of the slow oscillator
  logic       base_tick;       // tick chosen by the external select bit
  logic       tick_lo;         // tick for low byte or whole timer
  logic       tick_hi;         // tick for split high byte
  logic       run;             // run control bit
  logic       cap_evt;         // capture event this cycle
  logic       set_hi;          // hardware sets high flag
  logic       set_lo;          // hardware sets low flag
  logic [15:0] count16;        // both count bytes as one value
  logic [15:0] count16_inc;    // incremented 16-bit value
  arct_pkg::arct_mode_e mode;  // current operating mode

  arct_tick_if tick ();        // prescaled ticks from the generator

  // ************************************************************
  // tick generator
  // ************************************************************
  arct_tick_gen u_tick_gen (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_ext_osc (i_ext_osc),
    .tick      (tick.gen)
  );

  // ************************************************************
  // decoding helpers
  // ************************************************************
  // write strobe aimed at one register
  function automatic logic wr_at(input logic [7:0] addr);
    wr_at = i_sfr_wr && (i_sfr_addr == addr);
  endfunction : wr_at

  // address is one of the five timer registers
  function automatic logic in_map(input logic [7:0] addr);
    in_map = (addr == `ARCT_ADDR_CTRL) || (addr == `ARCT_ADDR_RELOAD_LO) ||
             (addr == `ARCT_ADDR_RELOAD_HI) || (addr == `ARCT_ADDR_COUNT_LO) ||
             (addr == `ARCT_ADDR_COUNT_HI);
  endfunction : in_map

  // ************************************************************
  // clock selection and events
  // ************************************************************
  // outside split mode the low select drives both bytes, so the high select is ignored
  always_comb begin
    mode      = arct_pkg::arct_mode_e'({ctrl[`ARCT_BIT_CAPTURE_EN], ctrl[`ARCT_BIT_SPLIT]});
    run       = ctrl[`ARCT_BIT_RUN];
    base_tick = ctrl[`ARCT_BIT_EXT_SEL] ? tick.ext8_tick : tick.sys12_tick;
    tick_lo   = i_low_byte_clock_select ? 1'b1 : base_tick;
    tick_hi   = i_high_byte_clock_select ? 1'b1 : base_tick;
    slow_fall = ~slow_s2 & slow_s3;
    // source select: zero picks start-of-frame, one picks oscillator fall
    cap_evt   = ctrl[`ARCT_BIT_CAPTURE_EN] &
                (ctrl[`ARCT_BIT_CAP_SRC] ? slow_fall : i_usb_sof);
    count16     = {count_hi, count_lo};
    count16_inc = count16 + `ARCT_WORD_ONE;
  end

  // ************************************************************
  // counter, reload and flag next state
  // ************************************************************
  // counting first, then software writes, then capture; flag sets beat clears
  always_comb begin
    next_count_lo  = count_lo;
    next_count_hi  = count_hi;
    next_reload_lo = reload_lo;
    next_reload_hi = reload_hi;
    set_hi         = 1'b0;
    set_lo         = 1'b0;
    case (mode)
      // single 16-bit counter, reloaded on full wrap
      arct_pkg::ARCT_MODE_RELOAD16: begin
        if (run && tick_lo) begin
          if (count16 == `ARCT_WORD_ONES) begin
            {next_count_hi, next_count_lo} = {reload_hi, reload_lo};
            set_hi = 1'b1;
            set_lo = 1'b1;
          end else begin
            {next_count_hi, next_count_lo} = count16_inc;
            set_lo = (count_lo == `ARCT_BYTE_ONES);
          end
        end
      end
      // two 8-bit counters; the low one ignores the run bit
      arct_pkg::ARCT_MODE_SPLIT8: begin
        if (tick_lo) begin
          if (count_lo == `ARCT_BYTE_ONES) begin
            next_count_lo = reload_lo;
            set_lo = 1'b1;
          end else begin
            next_count_lo = count_lo + `ARCT_BYTE_ONE;
          end
        end
        if (run && tick_hi) begin
          if (count_hi == `ARCT_BYTE_ONES) begin
            next_count_hi = reload_hi;
            set_hi = 1'b1;
          end else begin
            next_count_hi = count_hi + `ARCT_BYTE_ONE;
          end
        end
      end
      // free 16-bit count that wraps to zero
      arct_pkg::ARCT_MODE_CAP16: begin
        if (run && tick_lo) begin
          {next_count_hi, next_count_lo} = count16_inc;
          set_hi = (count16 == `ARCT_WORD_ONES);
          set_lo = (count_lo == `ARCT_BYTE_ONES);
        end
      end
      // two free 8-bit counts, each wrapping to zero
      arct_pkg::ARCT_MODE_CAP8: begin
        if (tick_lo) begin
          next_count_lo = count_lo + `ARCT_BYTE_ONE;
          set_lo = (count_lo == `ARCT_BYTE_ONES);
        end
        if (run && tick_hi) begin
          next_count_hi = count_hi + `ARCT_BYTE_ONE;
          set_hi = (count_hi == `ARCT_BYTE_ONES);
        end
      end
      default: begin
        next_count_lo = count_lo;
      end
    endcase
    // software writes replace the value the counter would have taken
    if (wr_at(`ARCT_ADDR_COUNT_LO)) begin
      next_count_lo = i_sfr_wdata;
    end
    if (wr_at(`ARCT_ADDR_COUNT_HI)) begin
      next_count_hi = i_sfr_wdata;
    end
    if (wr_at(`ARCT_ADDR_RELOAD_LO)) begin
      next_reload_lo = i_sfr_wdata;
    end
    if (wr_at(`ARCT_ADDR_RELOAD_HI)) begin
      next_reload_hi = i_sfr_wdata;
    end
    // a capture in the same cycle as a reload write wins, so no sample is lost
    if (cap_evt) begin
      next_reload_lo = count_lo;
      next_reload_hi = count_hi;
      set_hi         = 1'b1;
    end
    // flags only clear by software write; hardware sets win over that clear
    next_ctrl = wr_at(`ARCT_ADDR_CTRL) ? i_sfr_wdata : ctrl;
    next_ctrl[`ARCT_BIT_HI_FLAG] = next_ctrl[`ARCT_BIT_HI_FLAG] | set_hi;
    next_ctrl[`ARCT_BIT_LO_FLAG] = next_ctrl[`ARCT_BIT_LO_FLAG] | set_lo;
  end

  // ************************************************************
  // read path
  // ************************************************************
  // read data is sampled from the registers before this cycle's write lands
  always_comb begin
    case (i_sfr_addr)
      `ARCT_ADDR_CTRL:      next_rdata = ctrl;
      `ARCT_ADDR_RELOAD_LO: next_rdata = reload_lo;
      `ARCT_ADDR_RELOAD_HI: next_rdata = reload_hi;
      `ARCT_ADDR_COUNT_LO:  next_rdata = count_lo;
      `ARCT_ADDR_COUNT_HI:  next_rdata = count_hi;
      default:              next_rdata = `ARCT_RST_BYTE;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl      <= `ARCT_RST_BYTE;
      reload_lo <= `ARCT_RST_BYTE;
      reload_hi <= `ARCT_RST_BYTE;
      count_lo  <= `ARCT_RST_BYTE;
      count_hi  <= `ARCT_RST_BYTE;
      rdata     <= `ARCT_RST_BYTE;
      slow_s1   <= 1'b0;
      slow_s2   <= 1'b0;
      slow_s3   <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      reload_lo <= next_reload_lo;
      reload_hi <= next_reload_hi;
      count_lo  <= next_count_lo;
      count_hi  <= next_count_hi;
      rdata     <= next_rdata;
      slow_s1   <= i_low_freq_oscillator;
      slow_s2   <= slow_s1;
      slow_s3   <= slow_s2;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the request is a level; the low flag joins only when its enable is set
  assign o_timer_irq = i_timer_irq_enable & (ctrl[`ARCT_BIT_HI_FLAG] |
                       (ctrl[`ARCT_BIT_LO_IRQ_EN] & ctrl[`ARCT_BIT_LO_FLAG]));
  assign o_sfr_rdata = rdata;
  assign o_sfr_hit   = in_map(i_sfr_addr);

  // ************************************************************
  // checks
  // ************************************************************
  // one clock domain, so every check shares one clocking block and one reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  chk_reload_wrap_load: assert property (
    mode == arct_pkg::ARCT_MODE_RELOAD16 && run && tick_lo && count16 == `ARCT_WORD_ONES &&
    !wr_at(`ARCT_ADDR_COUNT_LO) && !wr_at(`ARCT_ADDR_COUNT_HI)
    |=> {count_hi, count_lo} == $past({reload_hi, reload_lo}) && ctrl[`ARCT_BIT_HI_FLAG])
    else $error("16-bit wrap did not reload or set flag");
  chk_run_hold: assert property (
    mode == arct_pkg::ARCT_MODE_RELOAD16 && !run && !i_sfr_wr |=> $stable(count16))
    else $error("stopped 16-bit counter moved");
  chk_split_low_free: assert property (
    mode == arct_pkg::ARCT_MODE_SPLIT8 && !run && tick_lo && count_lo != `ARCT_BYTE_ONES &&
    !i_sfr_wr |=> count_lo == 8'($past(count_lo) + `ARCT_BYTE_ONE) && $stable(count_hi))
    else $error("split low byte not free running");
  chk_split_high_wrap: assert property (
    mode == arct_pkg::ARCT_MODE_SPLIT8 && run && tick_hi && count_hi == `ARCT_BYTE_ONES &&
    !wr_at(`ARCT_ADDR_COUNT_HI) |=> count_hi == $past(reload_hi) && ctrl[`ARCT_BIT_HI_FLAG])
    else $error("split high wrap wrong");
  chk_flag_sticky: assert property (
    ctrl[`ARCT_BIT_HI_FLAG] && !wr_at(`ARCT_ADDR_CTRL) |=> ctrl[`ARCT_BIT_HI_FLAG])
    else $error("high flag dropped without a write");
  chk_irq_from_flag: assert property (
    ctrl[`ARCT_BIT_HI_FLAG] && i_timer_irq_enable |-> o_timer_irq)
    else $error("high flag with enable gave no request");
  chk_low_irq_gate: assert property (
    !ctrl[`ARCT_BIT_HI_FLAG] && !ctrl[`ARCT_BIT_LO_IRQ_EN] |-> !o_timer_irq)
    else $error("low flag requested while masked");
  chk_capture_copy: assert property (
    cap_evt |=> reload_lo == $past(count_lo) && reload_hi == $past(count_hi))
    else $error("capture did not copy count");
  // the enable may drop a cycle later, so the flag carries the check then
  chk_capture_irq: assert property (
    cap_evt && i_timer_irq_enable |=> ctrl[`ARCT_BIT_HI_FLAG] &&
    (o_timer_irq || !i_timer_irq_enable))
    else $error("capture raised no request");
  chk_count_write: assert property (
    wr_at(`ARCT_ADDR_COUNT_LO) |=> count_lo == $past(i_sfr_wdata))
    else $error("count write not taken");
  // split low byte reloads on its own wrap, whatever the run bit says
  chk_split_low_wrap: assert property (
    mode == arct_pkg::ARCT_MODE_SPLIT8 && tick_lo && count_lo == `ARCT_BYTE_ONES &&
    !wr_at(`ARCT_ADDR_COUNT_LO) |=> count_lo == $past(reload_lo) && ctrl[`ARCT_BIT_LO_FLAG])
    else $error("split low wrap wrong");
  // a stopped split high byte keeps its value
  chk_split_high_hold: assert property (
    mode == arct_pkg::ARCT_MODE_SPLIT8 && !run && !wr_at(`ARCT_ADDR_COUNT_HI)
    |=> $stable(count_hi))
    else $error("stopped split high byte moved");
  // a split high byte on the system clock steps every cycle while it runs
  chk_split_high_fast: assert property (
    mode == arct_pkg::ARCT_MODE_SPLIT8 && run && i_high_byte_clock_select &&
    count_hi != `ARCT_BYTE_ONES && !wr_at(`ARCT_ADDR_COUNT_HI)
    |=> count_hi == 8'($past(count_hi) + `ARCT_BYTE_ONE))
    else $error("split high byte on system clock did not step");
  // 16-bit low byte wrap raises the low flag
  chk_low_wrap_flag: assert property (
    mode == arct_pkg::ARCT_MODE_RELOAD16 && run && tick_lo && count_lo == `ARCT_BYTE_ONES
    |=> ctrl[`ARCT_BIT_LO_FLAG])
    else $error("16-bit low wrap did not set low flag");
  // capture counts wrap to zero rather than reload
  chk_cap16_wrap: assert property (
    mode == arct_pkg::ARCT_MODE_CAP16 && run && tick_lo && count16 == `ARCT_WORD_ONES &&
    !wr_at(`ARCT_ADDR_COUNT_LO) && !wr_at(`ARCT_ADDR_COUNT_HI)
    |=> count_hi == `ARCT_RST_BYTE && count_lo == `ARCT_RST_BYTE)
    else $error("16-bit capture count did not wrap to zero");
  chk_cap8_low_wrap: assert property (
    mode == arct_pkg::ARCT_MODE_CAP8 && tick_lo && count_lo == `ARCT_BYTE_ONES &&
    !wr_at(`ARCT_ADDR_COUNT_LO) |=> count_lo == `ARCT_RST_BYTE && ctrl[`ARCT_BIT_LO_FLAG])
    else $error("split capture low byte did not wrap to zero");
  // with the external select low and no system clock pick, only the twelfth clock steps
  chk_prescale_gate: assert property (
    mode == arct_pkg::ARCT_MODE_RELOAD16 && !i_low_byte_clock_select &&
    !ctrl[`ARCT_BIT_EXT_SEL] && !tick.sys12_tick && !i_sfr_wr |=> $stable(count16))
    else $error("16-bit count moved without a prescaled tick");
  // read data shows the register addressed one cycle before
  chk_read_reload_lo: assert property (
    i_sfr_addr == `ARCT_ADDR_RELOAD_LO |=> o_sfr_rdata == $past(reload_lo))
    else $error("reload low read back wrong");

  cov_reload_wrap: cover property (
    mode == arct_pkg::ARCT_MODE_RELOAD16 && run && tick_lo && count16 == `ARCT_WORD_ONES);
  cov_split_wrap: cover property (mode == arct_pkg::ARCT_MODE_SPLIT8 && set_hi && set_lo);
  cov_split_capture: cover property (mode == arct_pkg::ARCT_MODE_CAP8 && cap_evt);
  cov_capture_slow: cover property (cap_evt && ctrl[`ARCT_BIT_CAP_SRC]);
  cov_capture_sof: cover property (cap_evt && !ctrl[`ARCT_BIT_CAP_SRC]);

endmodule : arct_timer

/* File: test/arct_osc_model.sv */
// oscillator partner: free external oscillator and a commanded low frequency oscillator
`timescale 1ns/1ps
module arct_osc_model (
  input  wire logic i_slow_level,          // level the low frequency oscillator shows
  output logic      o_ext_osc,             // free-running external oscillator
  output logic      o_low_freq_oscillator  // low frequency oscillator pin
);
  // 100 ns period, offset 3 ns so no edge meets a system clock edge
  initial begin
    o_ext_osc = 1'b0;
    #3;
    forever #50 o_ext_osc = ~o_ext_osc;
  end
  // the bench picks the moment of each falling edge
  assign o_low_freq_oscillator = i_slow_level;
endmodule : arct_osc_model

/* File: test/arct_timer_tb.sv */
// self-checking testbench of the timer through its register bus
`timescale 1ns/1ps
`include "arct_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module arct_timer_tb;
  logic       i_sys_clk, i_srst, i_sfr_wr, o_sfr_hit, i_lsel, i_hsel, i_irq_en;
  logic       i_usb_sof, ext_osc, slow_osc, slow_lvl, o_timer_irq, hv;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, rv;
  int         err_count, n_compared;
  arct_timer u_arct_timer (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .i_low_byte_clock_select(i_lsel), .i_high_byte_clock_select(i_hsel),
    .i_timer_irq_enable(i_irq_en), .i_usb_sof(i_usb_sof), .i_ext_osc(ext_osc),
    .i_low_freq_oscillator(slow_osc), .o_timer_irq(o_timer_irq));
  arct_osc_model u_arct_osc_model (.i_slow_level(slow_lvl), .o_ext_osc(ext_osc),
    .o_low_freq_oscillator(slow_osc));
  // ************************************************************
  // bus tasks: each is entered just after a rising edge
  // ************************************************************
  // write taken at the next edge; strobe left high so writes may run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr  <= a;
    i_sfr_wr    <= 1'b1;
    i_sfr_wdata <= d;
    @(posedge i_sys_clk);
  endtask : wr
  task automatic idle(input int n);
    i_sfr_wr <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
  endtask : idle
  // read data is registered, so it is looked at just after the edge that follows the address
  task automatic rd(input logic [7:0] a);
    i_sfr_wr   <= 1'b0;
    i_sfr_addr <= a;
    @(posedge i_sys_clk);
    #1;
    rv = o_sfr_rdata;
    hv = o_sfr_hit;
    @(posedge i_sys_clk);
  endtask : rd
  // run bit high for exactly n edges, giving n steps on the system clock
  task automatic run(input logic [7:0] c, input int n);
    wr(`ARCT_ADDR_CTRL, c | 8'h04);
    if (n > 1) idle(n - 1);
    wr(`ARCT_ADDR_CTRL, c);
  endtask : run
  task automatic conclude();
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // ************************************************************
  // clock, watchdog and test sequence
  // ************************************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // the sequence needs about 1000 cycles; a hang is cut well beyond that
  initial begin
    #200000;
    err_count++;
    conclude();
  end
  initial begin
    {i_srst, i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, 1'b0, 8'h00, 8'h00};
    {i_lsel, i_hsel, i_irq_en, i_usb_sof, slow_lvl} = 5'b11101;
    err_count = 0;
    n_compared = 0;
    repeat (20) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    // reset values and an unmapped address
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'h00)
    `CHK(hv, 1'b1)
    rd(`ARCT_ADDR_RELOAD_LO); `CHK(rv, 8'h00)
    rd(8'hC9);                `CHK(rv, 8'h00)
    `CHK(hv, 1'b0)
    `CHK(o_timer_irq, 1'b0)
    wr(`ARCT_ADDR_COUNT_LO, 8'h55);
    rd(`ARCT_ADDR_COUNT_LO);  `CHK(rv, 8'h55)
    // full wrap reloads; the clearing write in the same cycle loses to the flag set
    wr(`ARCT_ADDR_COUNT_LO, 8'hFF);
    wr(`ARCT_ADDR_COUNT_HI, 8'hFF);
    wr(`ARCT_ADDR_RELOAD_LO, 8'h34);
    wr(`ARCT_ADDR_RELOAD_HI, 8'h12);
    run(8'h00, 1);
    rd(`ARCT_ADDR_COUNT_HI);  `CHK(rv, 8'h12)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'hC0)
    `CHK(o_timer_irq, 1'b1)
    idle(50);
    rd(`ARCT_ADDR_COUNT_LO);  `CHK(rv, 8'h34)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'hC0)
    wr(`ARCT_ADDR_CTRL, 8'h00);
    rd(`ARCT_ADDR_CTRL);      `CHK(o_timer_irq, 1'b0)
    // low byte wrap carries into the high byte, low interrupt enabled
    wr(`ARCT_ADDR_COUNT_HI, 8'h00);
    wr(`ARCT_ADDR_COUNT_LO, 8'hFF);
    run(8'h20, 1);
    rd(`ARCT_ADDR_COUNT_HI);  `CHK(rv, 8'h01)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'h60)
    `CHK(o_timer_irq, 1'b1)
    // prescaled rates: 120 edges give ten steps at /12, 400 edges ten at external /8
    i_lsel <= 1'b0;
    wr(`ARCT_ADDR_COUNT_LO, 8'h00);
    run(8'h00, 120);
    rd(`ARCT_ADDR_COUNT_LO);  `CHK(rv, 8'h0A)
    wr(`ARCT_ADDR_COUNT_LO, 8'h00);
    run(8'h01, 400);
    rd(`ARCT_ADDR_COUNT_LO);  `CHK(rv, 8'h0A)
    // split: low byte runs with run bit off, high byte held
    i_lsel <= 1'b1;
    wr(`ARCT_ADDR_RELOAD_LO, 8'h11);
    wr(`ARCT_ADDR_RELOAD_HI, 8'h22);
    wr(`ARCT_ADDR_COUNT_HI, 8'hFF);
    wr(`ARCT_ADDR_CTRL, 8'h08);
    idle(300);
    rd(`ARCT_ADDR_COUNT_HI);  `CHK(rv, 8'hFF)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'h48)
    `CHK(o_timer_irq, 1'b0)
    wr(`ARCT_ADDR_CTRL, 8'h68);
    rd(`ARCT_ADDR_COUNT_LO);  `CHK(o_timer_irq, 1'b1)
    `CHK(rv >= 8'h11, 1'b1)
    run(8'h08, 1);
    rd(`ARCT_ADDR_COUNT_HI);  `CHK(rv, 8'h22)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv & 8'h80, 8'h80)
    // high byte on the prescaled tick: twelve edges of run give one step
    i_hsel <= 1'b0;
    wr(`ARCT_ADDR_COUNT_HI, 8'h00);
    run(8'h08, 12);
    rd(`ARCT_ADDR_COUNT_HI);  `CHK(rv, 8'h01)
    // capture on start-of-frame, count held with run bit off
    wr(`ARCT_ADDR_CTRL, 8'h00);
    wr(`ARCT_ADDR_COUNT_LO, 8'h21);
    wr(`ARCT_ADDR_COUNT_HI, 8'h43);
    wr(`ARCT_ADDR_CTRL, 8'h10);
    i_usb_sof <= 1'b1;
    idle(1);
    i_usb_sof <= 1'b0;
    idle(2);
    rd(`ARCT_ADDR_RELOAD_LO); `CHK(rv, 8'h21)
    rd(`ARCT_ADDR_RELOAD_HI); `CHK(rv, 8'h43)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'h90)
    `CHK(o_timer_irq, 1'b1)
    // capture on a falling edge of the low frequency oscillator
    wr(`ARCT_ADDR_CTRL, 8'h12);
    wr(`ARCT_ADDR_COUNT_LO, 8'h5A);
    idle(4);
    slow_lvl <= 1'b0;
    idle(8);
    rd(`ARCT_ADDR_RELOAD_LO); `CHK(rv, 8'h5A)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'h92)
    // split capture: low byte free, high byte held, each byte copied on a frame start
    wr(`ARCT_ADDR_CTRL, 8'h18);
    wr(`ARCT_ADDR_COUNT_HI, 8'h77);
    wr(`ARCT_ADDR_COUNT_LO, 8'hFE);
    i_usb_sof <= 1'b1;
    idle(1);
    i_usb_sof <= 1'b0;
    rd(`ARCT_ADDR_RELOAD_LO); `CHK(rv, 8'hFE)
    rd(`ARCT_ADDR_RELOAD_HI); `CHK(rv, 8'h77)
    rd(`ARCT_ADDR_COUNT_HI);  `CHK(rv, 8'h77)
    rd(`ARCT_ADDR_CTRL);      `CHK(rv, 8'hD8)
    conclude();
  end
endmodule : arct_timer_tb
